//--- rtl/prmc_top.sv
// Power reduction mode controller: idle and power-down entry, exit and clock choice
// Operation
// R1: Idle stops CPU, peripherals keep running
// R2: Any interrupt ends idle, resume next
// R3: Pending external bus cycles finish first
// R4: Refuse entry if ready enabled but missed
// R5: Power-down stops everything except RTC path
// R6: Low-power oscillator running: stop main oscillator
// R7: Detect low-power oscillator, keep unless disabled
// R8: Only main oscillator: keep it running
// R9: Software sets regulator off before power-down
// R10: Variant bit clear selects protected power-down
// R11: Protected entry needs NMI pin low
// R12: Protected exit only by reset pin
// R13: Variant bit set selects interruptible power-down
// R14: Interruptible entry needs enabled pins inactive
// R15: Interruptible exit: reset, pins, RTC, CAN, I2C
// R16: Wake pins held at least 40 ns
// R17: Reset held long enough for PLL
// R18: Refused entry continues with next instruction
`timescale 1ns/10ps
`default_nettype none

module prmc_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // CPU instruction strobes
    input wire prmc_pkg::prmc_cpu_cmd_t cmd_i,
    // External bus status
    input wire prmc_pkg::prmc_bus_t bus_i,
    // Configuration words
    input wire logic [prmc_pkg::SYSCFG_W-1:0] system_config_register_i,
    input wire logic [prmc_pkg::MISC_W-1:0] misc_control_register_i,
    // Pins
    input wire logic nmi_n_i,                                    // NMI pin, active low
    input wire logic [prmc_pkg::FEI_W-1:0] fast_external_interrupt_pin_i,
    input wire logic [prmc_pkg::FEI_W-1:0] fei_enable_i,         // Pin enables
    input wire logic [prmc_pkg::FEI_W-1:0] fei_active_high_i,    // Active level per pin
    // Wake sources and oscillator status
    input wire prmc_pkg::prmc_wake_t wake_i,
    input wire logic lowpower_osc_running_i,   // Low-power oscillator detected
    input wire logic lowpower_osc_disable_i,   // Software disables its use
    // Outputs
    output var prmc_pkg::prmc_clk_t clk_ctl_o,
    output var prmc_pkg::prmc_state_t state_o,
    output logic entry_refused_o,              // One-cycle pulse: entry refused
    output logic wake_o,                       // One-cycle pulse: idle or interruptible power-down left by a wake source
    output logic regulator_off_warn_o          // Power-down entered, regulator on
);
    import prmc_pkg::*;

    //--------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------
    prmc_state_t state_r, state_nxt;     // Mode state
    prmc_req_t req_r, req_nxt;           // Request waiting for bus drain
    logic interruptible_r, interruptible_nxt;  // Power-down variant captured
    logic lp_sel_r, lp_sel_nxt;          // Low-power oscillator adopted
    prmc_clk_t clk_r, clk_nxt;
    logic refused_r, refused_nxt;
    logic wake_r, wake_nxt;
    logic warn_r, warn_nxt;
    logic [FEI_W-1:0] pin_act;           // Pins at active level
    logic [FEI_W-1:0] pin_qual;          // Pins held for least width
    logic pins_quiet;                    // All enabled pins inactive
    logic pin_wake;                      // A qualified pin wake
    logic variant_int;                   // Interruptible variant selected
    logic ready_ok;                      // Last access ready check passed
    logic pwd_ok;                        // Power-down entry condition met

    //--------------------------------------------------------------------
    // Fast external interrupt qualification
    //--------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < FEI_W; gi++) begin : g_fei
            assign pin_act[gi] = ~(fast_external_interrupt_pin_i[gi] ^ fei_active_high_i[gi]);
            // R16: minimum pulse width
            prmc_pulse_filter u_filt (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .active_i(pin_act[gi]),
                .enable_i(fei_enable_i[gi]),
                .qualified_o(pin_qual[gi])
            );
        end
    endgenerate

    assign pins_quiet = ~|(pin_act & fei_enable_i);
    assign pin_wake = |pin_qual;
    // R10: R13: variant select bit
    assign variant_int = system_config_register_i[PWD_VARIANT_BIT];
    // R4: ready handshake check
    assign ready_ok = ~bus_i.ready_en | bus_i.ready_seen;
    // R11: R14: variant entry conditions
    assign pwd_ok = variant_int ? pins_quiet : ~nmi_n_i;

    //--------------------------------------------------------------------
    // Mode state machine
    //--------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        interruptible_nxt = interruptible_r;
        refused_nxt = 1'b0;
        wake_nxt = 1'b0;
        warn_nxt = warn_r;
        unique case (state_r)
            PRMC_RUN: begin
                if (cmd_i.idle_instr) begin
                    req_nxt = PRMC_REQ_IDLE;
                    state_nxt = PRMC_DRAIN;
                end else if (cmd_i.powerdown_entry_instruction) begin
                    req_nxt = PRMC_REQ_PWD;
                    interruptible_nxt = variant_int;
                    state_nxt = PRMC_DRAIN;
                end
            end
            PRMC_DRAIN: begin
                // R3: wait for external bus cycles
                if (!bus_i.busy) begin
                    req_nxt = PRMC_REQ_NONE;
                    // R18: refused entry returns to run
                    if (!ready_ok) begin
                        refused_nxt = 1'b1;
                        state_nxt = PRMC_RUN;
                    end else if (req_r == PRMC_REQ_IDLE) begin
                        state_nxt = PRMC_IDLE;
                    end else if (pwd_ok) begin
                        state_nxt = PRMC_PWD;
                        // R9: flag regulator left on
                        warn_nxt = ~misc_control_register_i[REG_OFF_BIT];
                    end else begin
                        refused_nxt = 1'b1;
                        state_nxt = PRMC_RUN;
                    end
                end
            end
            PRMC_IDLE: begin
                // R2: any interrupt ends idle
                if (wake_i.any_irq) begin
                    wake_nxt = 1'b1;
                    state_nxt = PRMC_RUN;
                end
            end
            PRMC_PWD: begin
                // R12: R15: exit sources; reset pin acts via rst_i
                if (interruptible_r &&
                    (pin_wake || wake_i.rtc_irq || wake_i.can_wake || wake_i.i2c_wake)) begin
                    wake_nxt = 1'b1;
                    warn_nxt = 1'b0;
                    state_nxt = PRMC_RUN;
                end
            end
        endcase
    end

    //--------------------------------------------------------------------
    // Oscillator choice and clock enables
    //--------------------------------------------------------------------
    always_comb begin
        // R7: adopt low-power oscillator once detected
        lp_sel_nxt = (lp_sel_r | lowpower_osc_running_i) & ~lowpower_osc_disable_i;
        // R1: R5: CPU stops in idle and power-down, peripherals in power-down
        clk_nxt.cpu_clk_en = (state_nxt == PRMC_RUN) || (state_nxt == PRMC_DRAIN);
        clk_nxt.periph_clk_en = (state_nxt != PRMC_PWD);
        // R6: R8: main oscillator stops only when low-power one is in use
        clk_nxt.main_osc_en = !((state_nxt == PRMC_PWD) && lp_sel_nxt);
        clk_nxt.rtc_src_lowpower = lp_sel_nxt;
    end

    // Register all state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= PRMC_RUN;
            req_r <= PRMC_REQ_NONE;
            interruptible_r <= 1'b0;
            lp_sel_r <= 1'b0;
            clk_r <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, main_osc_en: 1'b1,
                       rtc_src_lowpower: 1'b0};
            refused_r <= 1'b0;
            wake_r <= 1'b0;
            warn_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            interruptible_r <= interruptible_nxt;
            lp_sel_r <= lp_sel_nxt;
            clk_r <= clk_nxt;
            refused_r <= refused_nxt;
            wake_r <= wake_nxt;
            warn_r <= warn_nxt;
        end
    end

    assign clk_ctl_o = clk_r;
    assign state_o = state_r;
    assign entry_refused_o = refused_r;
    assign wake_o = wake_r;
    assign regulator_off_warn_o = warn_r;

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    a_idle_cpu_stop: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        (state_r == PRMC_IDLE) |-> (!clk_r.cpu_clk_en && clk_r.periph_clk_en))
        else $error("idle clocks wrong");
    a_idle_irq_exit: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (state_r == PRMC_IDLE && wake_i.any_irq) |=> (state_r == PRMC_RUN && wake_r))
        else $error("idle not left on interrupt");
    a_drain_bus_wait: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        (state_r == PRMC_DRAIN && bus_i.busy) |=> (state_r == PRMC_DRAIN))
        else $error("entry before bus drained");
    a_ready_refuse: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        (state_r == PRMC_DRAIN && !bus_i.busy && !ready_ok) |=> (refused_r && state_r == PRMC_RUN))
        else $error("missing ready not refused");
    a_pwd_all_stop: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        (state_r == PRMC_PWD) |-> (!clk_r.cpu_clk_en && !clk_r.periph_clk_en))
        else $error("power-down clocks running");
    a_main_osc_lp: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        (state_r == PRMC_PWD && lp_sel_r) |-> !clk_r.main_osc_en)
        else $error("main oscillator not stopped");
    a_lp_keep: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (lp_sel_r && !lowpower_osc_disable_i) |=> lp_sel_r)
        else $error("low-power choice lost");
    a_main_osc_keep: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (!lp_sel_r) |-> clk_r.main_osc_en)
        else $error("main oscillator stopped without low-power");
    a_prot_nmi: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        (state_r == PRMC_DRAIN && req_r == PRMC_REQ_PWD && !bus_i.busy && ready_ok
         && !interruptible_r && nmi_n_i) |=> refused_r)
        else $error("protected entry without NMI");
    a_prot_stay: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        (state_r == PRMC_PWD && !interruptible_r) |=> (state_r == PRMC_PWD))
        else $error("protected power-down left without reset");
    a_int_pins_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        (state_r == PRMC_DRAIN && req_r == PRMC_REQ_PWD && !bus_i.busy && ready_ok
         && interruptible_r && !pins_quiet) |=> refused_r)
        else $error("interruptible entry with active pin");
    a_int_wake: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        (state_r == PRMC_PWD && interruptible_r && wake_i.rtc_irq) |=> (state_r == PRMC_RUN))
        else $error("interruptible wake missed");
    // Wake only after an enabled pin stood active at both ends of the least width
    a_pin_width: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        $rose(pin_wake) |-> (($past(pin_act & fei_enable_i, 1) != '0)
                             && ($past(pin_act & fei_enable_i, WAKE_CYC) != '0)))
        else $error("pin wake without long enough pin pulse");

    c_idle_cycle: cover property (@(posedge clk_i) disable iff (rst_i)
        state_r == PRMC_IDLE ##[1:50] state_r == PRMC_RUN);
    c_pwd_wake: cover property (@(posedge clk_i) disable iff (rst_i)
        state_r == PRMC_PWD ##1 wake_r);
    c_refused: cover property (@(posedge clk_i) disable iff (rst_i) refused_r);
    c_lp_pwd: cover property (@(posedge clk_i) disable iff (rst_i)
        state_r == PRMC_PWD && !clk_r.main_osc_en);

endmodule
`default_nettype wire

//--- rtl/prmc_pkg.sv
// Package: constants, types and state codes of the power reduction mode controller
package prmc_pkg;

    //--------------------------------------------------------------------
    // Widths and field positions
    //--------------------------------------------------------------------
    localparam int unsigned FEI_W = 8;            // Fast external interrupt pins
    localparam int unsigned SYSCFG_W = 16;        // System configuration word
    localparam int unsigned PWD_VARIANT_BIT = 5;  // Power-down variant select bit
    localparam int unsigned MISC_W = 16;          // Misc control word
    localparam int unsigned REG_OFF_BIT = 0;      // Regulator off control bit (assumed)

    //--------------------------------------------------------------------
    // Timing
    //--------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 4000;       // 250 MHz clock period
    localparam int unsigned WAKE_PULSE_MIN_PS = 40000;  // Least wake pulse, 40 ns
    // Least time rounds up to whole cycles
    localparam int unsigned WAKE_CYC =
        (WAKE_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WCNT_W = 4;
    localparam logic [WCNT_W-1:0] WCNT_ZERO = 4'h0;
    localparam logic [WCNT_W-1:0] WCNT_ONE = 4'h1;
    localparam logic [WCNT_W-1:0] WCNT_DONE = WCNT_W'(WAKE_CYC);

    //--------------------------------------------------------------------
    // Mode state, Gray coded along run, drain, idle, power-down
    //--------------------------------------------------------------------
    typedef enum logic [1:0] {
        PRMC_RUN = 2'h0,
        PRMC_DRAIN = 2'h1,
        PRMC_IDLE = 2'h3,
        PRMC_PWD = 2'h2
    } prmc_state_t;

    // Pending request kind
    typedef enum logic [1:0] {
        PRMC_REQ_NONE = 2'h0,
        PRMC_REQ_IDLE = 2'h1,
        PRMC_REQ_PWD = 2'h2
    } prmc_req_t;

    // Instruction strobes from the CPU core
    typedef struct packed {
        logic idle_instr;                    // Protected idle instruction executes
        logic powerdown_entry_instruction;   // Protected power-down instruction
    } prmc_cpu_cmd_t;

    // External bus status
    typedef struct packed {
        logic busy;          // External bus cycle pending
        logic ready_en;      // Ready handshake enabled
        logic ready_seen;    // Ready seen at programmed polarity on last access
    } prmc_bus_t;

    // Wake sources other than fast external interrupts
    typedef struct packed {
        logic any_irq;       // Any interrupt request (ends idle)
        logic rtc_irq;       // Real-time clock interrupt
        logic can_wake;      // CAN activity wake
        logic i2c_wake;      // I2C activity wake
    } prmc_wake_t;

    // Clock gating outputs
    typedef struct packed {
        logic cpu_clk_en;        // CPU clock running
        logic periph_clk_en;     // Peripherals and watchdog clocked
        logic main_osc_en;       // Main oscillator running
        logic rtc_src_lowpower;  // Real-time clock uses low-power oscillator
    } prmc_clk_t;

endpackage

//--- rtl/prmc_pulse_filter.sv
// Minimum width filter for one fast external interrupt pin
`timescale 1ns/10ps
`default_nettype none

module prmc_pulse_filter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin and qualifiers
    input wire logic active_i,    // Pin at active level
    input wire logic enable_i,    // Pin enabled as interrupt
    // Result
    output logic qualified_o      // Held active for the least width
);
    import prmc_pkg::*;

    //--------------------------------------------------------------------
    // Width counter
    //--------------------------------------------------------------------
    logic [WCNT_W-1:0] cnt_r;   // Cycles the pin has stayed active
    logic [WCNT_W-1:0] cnt_nxt;
    logic qual_r;
    logic qual_nxt;

    // Count while active, restart on release, saturate at the least width
    always_comb begin
        cnt_nxt = WCNT_ZERO;
        if (active_i && enable_i) begin
            cnt_nxt = (cnt_r == WCNT_DONE) ? cnt_r : cnt_r + WCNT_ONE;
        end
        qual_nxt = (cnt_nxt == WCNT_DONE);
    end

    // Register the count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= WCNT_ZERO;
            qual_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign qualified_o = qual_r;

endmodule
`default_nettype wire

//--- testbench/prmc_far_model.sv
// Far side model: fast external interrupt pins driven by an outside party
`timescale 1ns/10ps
`default_nettype none

module prmc_far_model (
    // Clock
    input wire logic clk_i,
    // Pulse request
    input wire logic go_i,                         // Start one wake pulse
    input wire logic [7:0] width_i,                // Pulse width in clock cycles
    input wire logic [2:0] idx_i,                  // Pin that carries the pulse
    input wire logic [prmc_pkg::FEI_W-1:0] active_high_i,
    // Pins
    output logic [prmc_pkg::FEI_W-1:0] pin_o
);
    import prmc_pkg::*;

    logic [7:0] left_r = 8'h00;  // Cycles of pulse still to drive
    logic [2:0] idx_r = 3'h0;    // Pin chosen for the pulse

    always_ff @(negedge clk_i) begin
        if (go_i) begin
            left_r <= width_i;
            idx_r <= idx_i;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end

    // Pins rest at their inactive level outside a pulse
    always_comb begin
        pin_o = ~active_high_i;
        if (left_r != 8'h00) begin
            pin_o[idx_r] = active_high_i[idx_r];
        end
    end
endmodule

`default_nettype wire

//--- testbench/power_reduction_mode_control_tb.sv
// Testbench: idle and power-down entry, refusal, wake and clock choice
`timescale 1ns/10ps
`default_nettype none

module power_reduction_mode_control_tb;
    import prmc_pkg::*;

    //--------------------------------------------------------------------
    // Signals
    //--------------------------------------------------------------------
    logic clk_i;
    logic rst_i;
    prmc_cpu_cmd_t cmd;
    prmc_bus_t bus;
    logic [SYSCFG_W-1:0] syscfg;
    logic [MISC_W-1:0] misc;
    logic nmi_n;
    logic [FEI_W-1:0] pins;
    logic [FEI_W-1:0] fei_en;
    logic [FEI_W-1:0] fei_ah;
    prmc_wake_t wake;
    logic lp_run;
    logic lp_dis;
    prmc_clk_t clk_ctl;
    prmc_state_t state;
    logic refused;
    logic woke;
    logic warn;
    logic go;
    logic [7:0] width;
    int errors = 0;
    int total_checks = 0;

    //--------------------------------------------------------------------
    // Instances
    //--------------------------------------------------------------------
    prmc_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .bus_i(bus),
        .system_config_register_i(syscfg), .misc_control_register_i(misc),
        .nmi_n_i(nmi_n), .fast_external_interrupt_pin_i(pins), .fei_enable_i(fei_en),
        .fei_active_high_i(fei_ah), .wake_i(wake), .lowpower_osc_running_i(lp_run),
        .lowpower_osc_disable_i(lp_dis), .clk_ctl_o(clk_ctl), .state_o(state),
        .entry_refused_o(refused), .wake_o(woke), .regulator_off_warn_o(warn)
    );

    prmc_far_model i_far (
        .clk_i(clk_i), .go_i(go), .width_i(width), .idx_i(3'h3),
        .active_high_i(fei_ah), .pin_o(pins)
    );

    // Clock of 4 ns period
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    //--------------------------------------------------------------------
    // Shared tasks
    //--------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Pulse one command, return after the decision edge
    task automatic issue(input logic idle);
        cmd = idle ? 2'h2 : 2'h1;
        tick(1);
        cmd = 2'h0;
        tick(1);
    endtask

    // Start a wake pulse on the far side
    task automatic pulse(input logic [7:0] w);
        @(negedge clk_i);
        go <= 1'b1;
        width <= w;
        @(negedge clk_i);
        go <= 1'b0;
    endtask

    task automatic end_sim;
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    //--------------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------------
    task automatic t_idle;
        bus.busy = 1'b1;
        issue(1'b1);
        tick(1);
        chk("state_drain", 8'(PRMC_DRAIN), {6'h00, state});  // Busy bus holds entry
        bus.busy = 1'b0;
        tick(1);
        chk("state_idle", 8'(PRMC_IDLE), {6'h00, state});  // Idle entered
        chk("cpu_en", 8'h00, {7'h00, clk_ctl.cpu_clk_en});  // CPU halted
        chk("periph_en", 8'h01, {7'h00, clk_ctl.periph_clk_en});  // Peripherals run
        wake.any_irq = 1'b1;
        tick(1);
        chk("idle_exit", 8'(PRMC_RUN), {6'h00, state});  // Interrupt ends idle
        chk("wake_o", 8'h01, {7'h00, woke});  // Wake pulse seen
        wake.any_irq = 1'b0;
        tick(1);
        chk("wake_end", 8'h00, {7'h00, woke});  // Pulse lasts one cycle
    endtask

    task automatic t_refuse;
        bus.ready_en = 1'b1;
        issue(1'b1);
        chk("refused", 8'h01, {7'h00, refused});  // Missing ready refuses
        chk("stay_run", 8'(PRMC_RUN), {6'h00, state});  // Execution continues
        bus.ready_seen = 1'b1;
        tick(1);
        chk("refuse_end", 8'h00, {7'h00, refused});  // Refusal pulse ends
    endtask

    task automatic t_protected;
        nmi_n = 1'b1;
        issue(1'b0);
        chk("nmi_high", 8'h01, {7'h00, refused});  // Outside NMI routine refused
        nmi_n = 1'b0;
        tick(1);
        issue(1'b0);
        chk("pwd", 8'(PRMC_PWD), {6'h00, state});  // Protected variant entered
        chk("clk_pwd", 8'h01, {4'h0, clk_ctl});  // All stopped, RTC on low-power
        chk("warn", 8'h01, {7'h00, warn});  // Regulator left on is flagged
        wake = 4'hF;
        tick(6);
        chk("no_irq_exit", 8'(PRMC_PWD), {6'h00, state});  // Interrupts cannot wake
        wake = 4'h0;
        nmi_n = 1'b1;
        rst_i = 1'b1;
        tick(3);
        rst_i = 1'b0;
        chk("rst_exit", 8'(PRMC_RUN), {6'h00, state});  // Reset pin wakes
        tick(2);
        chk("lp_keep", 8'h01, {7'h00, clk_ctl.rtc_src_lowpower});  // Re-adopted
        lp_run = 1'b0;
        lp_dis = 1'b1;
        tick(2);
        lp_dis = 1'b0;
        tick(2);
        chk("lp_drop", 8'h00, {7'h00, clk_ctl.rtc_src_lowpower});  // Software disable
    endtask

    task automatic t_interruptible;
        logic [3:0] src [3] = '{4'h4, 4'h2, 4'h1};
        syscfg = 16'h0020;
        misc = 16'h0001;
        pulse(8'h14);
        issue(1'b0);
        chk("pin_active", 8'h01, {7'h00, refused});  // Active enabled pin refuses
        tick(22);
        foreach (src[i]) begin
            issue(1'b0);
            chk("pwd_int", 8'(PRMC_PWD), {6'h00, state});  // Interruptible entered
            chk("main_osc", 8'h02, {4'h0, clk_ctl});  // Main oscillator kept
            wake = src[i];
            tick(1);
            chk("src_exit", 8'(PRMC_RUN), {6'h00, state});  // RTC, CAN, I2C wake
            wake = 4'h0;
            tick(1);
        end
        issue(1'b0);
        chk("no_warn", 8'h00, {7'h00, warn});  // Regulator off gives no flag
        pulse(8'(WAKE_CYC - 1));  // One cycle short of the least width
        tick(12);
        chk("short_pin", 8'(PRMC_PWD), {6'h00, state});  // Short pulse ignored
        pulse(8'(WAKE_CYC));  // Exactly the least width
        for (int n = 0; n < 14 && state != PRMC_RUN; n++) begin
            tick(1);
        end
        chk("pin_exit", 8'(PRMC_RUN), {6'h00, state});  // 40 ns pin pulse wakes
    endtask

    //--------------------------------------------------------------------
    // Main sequence and watchdog
    //--------------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        cmd = 2'h0;
        bus = 3'h0;
        syscfg = 16'h0000;
        misc = 16'h0000;
        nmi_n = 1'b1;
        fei_en = 8'h08;
        fei_ah = 8'hF7;
        wake = 4'h0;
        lp_run = 1'b1;
        lp_dis = 1'b0;
        go = 1'b0;
        width = 8'h00;
        tick(12);
        rst_i = 1'b0;
        tick(1);
        t_idle();
        t_refuse();
        t_protected();
        t_interruptible();
        end_sim();
    end

    // Cuts a hang short well past the expected run length
    initial begin
        repeat (2000) @(posedge clk_i);
        errors++;
        end_sim();
    end
endmodule

`default_nettype wire
